// [hdl/dmc_top.v]
// The address map and register access over AXI4-Lite were chosen for this implementation.
`include "dmc_consts.vh"

// What this block does
// - Ten channels with own source, addresses, count
// - Requests from software, converter, timer underflow, timer event
// - At most 256 transfers per programmed run
// - Addresses confined to fixed 64-Kbyte window
// - Read then write; bus released each transfer
// - Source/destination fixed, incrementing or ring
// - Fixed priority, channel 0 highest, 9 lowest
// - Sustain 13.3 Mbytes/s at 50 MHz clock with 16-bit moves (8-bit moves reach 12.5)
// - Count underflow raises grouped channel interrupt
// - Cascade loop channels 0 to 1 to 2
// - Cascade loop channels 5 to 6 to 7
// - Channel 3 transfer requests channel 4
// - Channel 8 transfer requests channel 9
// - Channel 0 underflow requests channel 5
// - Width bit: 0 sixteen bits, 1 eight
// - Pending flag cleared by writing 0 or when its transfer starts
// - Source select 00 soft, 01 conv, 10/11 timer
// - Ring mode bit; enable bit gates transfers
module dmc_top #(
  parameter RING_AW = `DMC_RING_AW
) (
  input  wire        sys_clk,
  input  wire        resetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [9:0]  src_req_conv,
  input  wire [9:0]  src_req_tudf,
  input  wire [9:0]  src_req_tevt,
  output reg         mbus_req,
  output reg         mbus_we,
  output reg         mbus_byte,
  output reg  [31:0] mbus_addr,
  output reg  [15:0] mbus_wdata,
  input  wire [15:0] mbus_rdata,
  input  wire        mbus_ack,
  output reg         irq
);
  localparam NCH      = `DMC_NCH;
  localparam IW       = `DMC_IDX_W;
  localparam ST_IDLE  = 2'd0;
  localparam ST_READ  = 2'd1;
  localparam ST_WRITE = 2'd2;
  localparam ST_DONE  = 2'd3;

  // ----------------------------------------------------------------
  // Bus slave write path
  // ----------------------------------------------------------------
  reg  [11:0] awaddr_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  reg         aw_full_reg;
  reg         w_full_reg;
  wire        aw_take;
  wire        w_take;
  wire        do_wr;
  wire        aw_full_next;
  wire        w_full_next;
  wire        wr_ch_hit;
  wire [IW-1:0] wr_ch;
  wire [1:0]  wr_fld;
  wire        wr_ok;

  assign aw_take      = s_axi_awvalid & s_axi_awready;
  assign w_take       = s_axi_wvalid & s_axi_wready;
  assign do_wr        = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign aw_full_next = do_wr ? 1'b0 : (aw_full_reg | aw_take);
  assign w_full_next  = do_wr ? 1'b0 : (w_full_reg | w_take);
  assign wr_ch        = awaddr_reg[7:4];
  assign wr_fld       = awaddr_reg[3:2];
  assign wr_ch_hit    = (awaddr_reg[11:8] == `DMC_CH_PAGE) && (wr_ch < NCH);
  assign wr_ok        = wr_ch_hit || (awaddr_reg == `DMC_OFS_ISTAT) ||
                        (awaddr_reg == `DMC_OFS_IMASK) ||
                        (awaddr_reg == `DMC_OFS_SWREQ);

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      awaddr_reg    <= 12'h000;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DMC_RESP_OK;
    end else begin
      if (aw_take) begin
        awaddr_reg <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      aw_full_reg   <= aw_full_next;
      w_full_reg    <= w_full_next;
      s_axi_awready <= ~aw_full_next;
      s_axi_wready  <= ~w_full_next;
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `DMC_RESP_OK : `DMC_RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Engine control signals shared with the channels
  // ----------------------------------------------------------------
  reg  [1:0]    state_reg;
  reg  [IW-1:0] cur_ch_reg;
  reg  [NCH-1:0] gnt_reg;
  wire [NCH-1:0] ready_vec;
  wire [NCH-1:0] gnt_vec;
  wire [IW-1:0]  gnt_idx;
  wire           gnt_any;
  wire [NCH-1:0] start_vec;
  wire [NCH-1:0] fin_vec;
  wire [NCH-1:0] uf_vec;
  wire [NCH-1:0] casc_vec;
  wire [NCH*8-1:0]  ctl_flat;
  wire [NCH*8-1:0]  cnt_flat;
  wire [NCH*16-1:0] src_flat;
  wire [NCH*16-1:0] dst_flat;
  wire [NCH-1:0]    pend_vec;
  wire [15:0]   src_nx;
  wire [15:0]   dst_nx;

  assign start_vec = (state_reg == ST_IDLE) ? gnt_vec : {NCH{1'b0}};
  assign fin_vec   = (state_reg == ST_DONE) ? gnt_reg : {NCH{1'b0}};

  // Cascade links; channels 3 and 8 have no inbound link
  assign casc_vec[1] = fin_vec[0];
  assign casc_vec[2] = fin_vec[1];
  assign casc_vec[0] = fin_vec[2];
  assign casc_vec[3] = 1'b0;
  assign casc_vec[4] = fin_vec[3];
  assign casc_vec[6] = fin_vec[5];
  assign casc_vec[7] = fin_vec[6];
  assign casc_vec[5] = fin_vec[7] | uf_vec[0];
  assign casc_vec[8] = 1'b0;
  assign casc_vec[9] = fin_vec[8];

  // ----------------------------------------------------------------
  // Per-channel registers
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch
      reg  [7:0]  ctl_reg;
      reg  [7:0]  cnt_reg;
      reg  [15:0] src_reg;
      reg  [15:0] dst_reg;
      reg         pend_reg;
      reg         trig;
      wire        wsel;
      wire        me_fin;

      assign wsel   = do_wr & wr_ch_hit & (wr_ch == i);
      assign me_fin = fin_vec[i];
      assign uf_vec[i] = me_fin & (cnt_reg == 8'h00);

      always @* begin
        case (ctl_reg[`DMC_CTL_SEL_HI:`DMC_CTL_SEL_LO])
          `DMC_SEL_SOFT: trig = casc_vec[i] | (do_wr & wstrb_reg[i/8] &
                                (awaddr_reg == `DMC_OFS_SWREQ) & wdata_reg[i]);
          `DMC_SEL_CONV: trig = src_req_conv[i];
          `DMC_SEL_TUDF: trig = src_req_tudf[i];
          `DMC_SEL_TEVT: trig = src_req_tevt[i];
          default:       trig = 1'b0;
        endcase
      end

      always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          ctl_reg  <= `DMC_CTL_RST;
          cnt_reg  <= `DMC_CNT_RST;
          src_reg  <= `DMC_ADDR_RST;
          dst_reg  <= `DMC_ADDR_RST;
          pend_reg <= 1'b0;
        end else begin
          // A new request wins over any clear in the same cycle
          if (trig) begin
            pend_reg <= 1'b1;
          end else if (start_vec[i]) begin
            pend_reg <= 1'b0;
          end else if (wsel && wr_fld == `DMC_FLD_CTL && wstrb_reg[0] &&
                       !wdata_reg[`DMC_CTL_PEND]) begin
            pend_reg <= 1'b0;
          end
          if (wsel && wstrb_reg[0]) begin
            case (wr_fld)
              `DMC_FLD_CTL: ctl_reg <= wdata_reg[7:0];
              `DMC_FLD_CNT: cnt_reg <= wdata_reg[7:0];
              `DMC_FLD_SRC: src_reg[7:0] <= wdata_reg[7:0];
              default:      dst_reg[7:0] <= wdata_reg[7:0];
            endcase
          end
          if (wsel && wstrb_reg[1]) begin
            if (wr_fld == `DMC_FLD_SRC) begin
              src_reg[15:8] <= wdata_reg[15:8];
            end
            if (wr_fld == `DMC_FLD_DST) begin
              dst_reg[15:8] <= wdata_reg[15:8];
            end
          end
          // Engine update lands after the bus write, so it wins
          if (me_fin) begin
            cnt_reg <= cnt_reg - 8'h01;
            src_reg <= src_nx;
            dst_reg <= dst_nx;
            if (cnt_reg == 8'h00) begin
              ctl_reg[`DMC_CTL_EN] <= 1'b0;
            end
          end
        end
      end

      assign ready_vec[i] = pend_reg & ctl_reg[`DMC_CTL_EN];
      assign ctl_flat[i*8 +: 8]   = ctl_reg;
      assign cnt_flat[i*8 +: 8]   = cnt_reg;
      assign src_flat[i*16 +: 16] = src_reg;
      assign dst_flat[i*16 +: 16] = dst_reg;
      assign pend_vec[i] = pend_reg;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Arbitration and address stepping
  // ----------------------------------------------------------------
  dmc_prio #(
    .N  (NCH),
    .IW (IW)
  ) u_prio (
    .req (ready_vec),
    .gnt (gnt_vec),
    .idx (gnt_idx),
    .any (gnt_any)
  );

  wire [IW-1:0] sel_ch;
  wire [7:0]    sel_ctl;
  wire [15:0]   sel_src;
  wire [15:0]   sel_dst;

  assign sel_ch  = (state_reg == ST_IDLE) ? gnt_idx : cur_ch_reg;
  assign sel_ctl = ctl_flat[sel_ch*8 +: 8];
  assign sel_src = src_flat[sel_ch*16 +: 16];
  assign sel_dst = dst_flat[sel_ch*16 +: 16];

  dmc_addr_step #(
    .RING_AW (RING_AW)
  ) u_src_step (
    .addr      (sel_src),
    .inc       (sel_ctl[`DMC_CTL_SINC]),
    .ring      (sel_ctl[`DMC_CTL_RING]),
    .byte_sz   (sel_ctl[`DMC_CTL_WID]),
    .addr_next (src_nx)
  );

  dmc_addr_step #(
    .RING_AW (RING_AW)
  ) u_dst_step (
    .addr      (sel_dst),
    .inc       (sel_ctl[`DMC_CTL_DINC]),
    .ring      (sel_ctl[`DMC_CTL_RING]),
    .byte_sz   (sel_ctl[`DMC_CTL_WID]),
    .addr_next (dst_nx)
  );

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  // Four states per transfer keep a 16-bit move well above 13.3 MB/s
  // at 50 MHz with single-cycle bus acks
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg  <= ST_IDLE;
      cur_ch_reg <= {IW{1'b0}};
      gnt_reg    <= {NCH{1'b0}};
      mbus_req   <= 1'b0;
      mbus_we    <= 1'b0;
      mbus_byte  <= 1'b0;
      mbus_addr  <= 32'h0000_0000;
      mbus_wdata <= 16'h0000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (gnt_any) begin
            state_reg  <= ST_READ;
            cur_ch_reg <= gnt_idx;
            gnt_reg    <= gnt_vec;
            mbus_req   <= 1'b1;
            mbus_we    <= 1'b0;
            mbus_byte  <= sel_ctl[`DMC_CTL_WID];
            mbus_addr  <= {`DMC_WIN_HI, sel_src};
          end
        end
        ST_READ: begin
          if (mbus_ack) begin
            state_reg  <= ST_WRITE;
            mbus_we    <= 1'b1;
            mbus_wdata <= mbus_rdata;
            mbus_addr  <= {`DMC_WIN_HI, sel_dst};
          end
        end
        ST_WRITE: begin
          if (mbus_ack) begin
            state_reg <= ST_DONE;
            mbus_req  <= 1'b0;
            mbus_we   <= 1'b0;
          end
        end
        ST_DONE: begin
          state_reg <= ST_IDLE;
          gnt_reg   <= {NCH{1'b0}};
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  reg  [NCH-1:0] istat_reg;
  reg  [NCH-1:0] imask_reg;
  wire [NCH-1:0] istat_next;
  wire           ar_take;
  wire           istat_rd;

  assign ar_take    = s_axi_arvalid & s_axi_arready;
  assign istat_rd   = ar_take && ({s_axi_araddr[11:2], 2'b00} == `DMC_OFS_ISTAT);
  // Underflow in the read cycle survives the read clear
  assign istat_next = (istat_rd ? {NCH{1'b0}} : istat_reg) | uf_vec;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      istat_reg <= `DMC_IRQ_RST;
      imask_reg <= `DMC_IRQ_RST;
      irq       <= 1'b0;
    end else begin
      istat_reg <= istat_next;
      if (do_wr && awaddr_reg == `DMC_OFS_IMASK) begin
        if (wstrb_reg[0]) begin
          imask_reg[7:0] <= wdata_reg[7:0];
        end
        if (wstrb_reg[1]) begin
          imask_reg[NCH-1:8] <= wdata_reg[NCH-1:8];
        end
      end
      irq <= |(istat_next & imask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Bus slave read path
  // ----------------------------------------------------------------
  wire [11:0]   rd_addr;
  wire [IW-1:0] rd_ch;
  wire          rd_ch_hit;
  reg  [31:0]   rd_data;
  reg           rd_ok;
  wire          rvalid_next;

  assign rd_addr     = {s_axi_araddr[11:2], 2'b00};
  assign rd_ch       = rd_addr[7:4];
  assign rd_ch_hit   = (rd_addr[11:8] == `DMC_CH_PAGE) && (rd_ch < NCH);
  assign rvalid_next = ar_take | (s_axi_rvalid & ~s_axi_rready);

  always @* begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (rd_ch_hit) begin
      case (rd_addr[3:2])
        `DMC_FLD_CTL: rd_data[7:0] = {ctl_flat[rd_ch*8+2 +: 6], pend_vec[rd_ch],
                                      ctl_flat[rd_ch*8]};
        `DMC_FLD_CNT: rd_data[7:0] = cnt_flat[rd_ch*8 +: 8];
        `DMC_FLD_SRC: rd_data[15:0] = src_flat[rd_ch*16 +: 16];
        default:      rd_data[15:0] = dst_flat[rd_ch*16 +: 16];
      endcase
    end else if (rd_addr == `DMC_OFS_ISTAT) begin
      rd_data[NCH-1:0] = istat_reg;
    end else if (rd_addr == `DMC_OFS_IMASK) begin
      rd_data[NCH-1:0] = imask_reg;
    end else if (rd_addr != `DMC_OFS_SWREQ) begin
      rd_ok = 1'b0;
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DMC_RESP_OK;
    end else begin
      if (ar_take) begin
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_ok ? `DMC_RESP_OK : `DMC_RESP_ERR;
      end
      s_axi_rvalid  <= rvalid_next;
      s_axi_arready <= ~rvalid_next;
    end
  end
endmodule

// [hdl/dmc_consts.vh]
`ifndef DMC_CONSTS_VH
`define DMC_CONSTS_VH

// ----------------------------------------------------------------
// Channel count and index width
// ----------------------------------------------------------------
`define DMC_NCH        10
`define DMC_IDX_W      4

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DMC_OFS_ISTAT  12'h000
`define DMC_OFS_IMASK  12'h004
`define DMC_OFS_SWREQ  12'h008
`define DMC_CH_PAGE    4'h1
`define DMC_FLD_CTL    2'h0
`define DMC_FLD_CNT    2'h1
`define DMC_FLD_SRC    2'h2
`define DMC_FLD_DST    2'h3

// ----------------------------------------------------------------
// Channel control fields
// ----------------------------------------------------------------
`define DMC_CTL_RING   0
`define DMC_CTL_PEND   1
`define DMC_CTL_SEL_HI 3
`define DMC_CTL_SEL_LO 2
`define DMC_CTL_EN     4
`define DMC_CTL_WID    5
`define DMC_CTL_SINC   6
`define DMC_CTL_DINC   7

`define DMC_SEL_SOFT   2'h0
`define DMC_SEL_CONV   2'h1
`define DMC_SEL_TUDF   2'h2
`define DMC_SEL_TEVT   2'h3

// ----------------------------------------------------------------
// Reset values, window, responses
// ----------------------------------------------------------------
`define DMC_CTL_RST    8'h00
`define DMC_CNT_RST    8'h00
`define DMC_ADDR_RST   16'h0000
`define DMC_IRQ_RST    10'h000
`define DMC_WIN_HI     16'h0080
`define DMC_RESP_OK    2'h0
`define DMC_RESP_ERR   2'h2
`define DMC_RING_AW    5

`endif

// [hdl/dmc_prio.v]
// ----------------------------------------------------------------
// Fixed priority pick, lowest index wins
// ----------------------------------------------------------------
module dmc_prio #(
  parameter N  = 10,
  parameter IW = 4
) (
  input  wire [N-1:0]  req,
  output wire [N-1:0]  gnt,
  output reg  [IW-1:0] idx,
  output wire          any
);
  wire [N:0] blk;
  integer    k;

  assign blk[0] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_pick
      assign blk[i+1] = blk[i] | req[i];
      assign gnt[i]   = req[i] & ~blk[i];
    end
  endgenerate
  assign any = blk[N];

  always @* begin
    idx = {IW{1'b0}};
    for (k = N - 1; k >= 0; k = k - 1) begin
      if (req[k]) begin
        idx = k[IW-1:0];
      end
    end
  end
endmodule

// [hdl/dmc_addr_step.v]
// ----------------------------------------------------------------
// Address advance: fixed, incrementing, or ring wrap
// ----------------------------------------------------------------
module dmc_addr_step #(
  parameter RING_AW = 5
) (
  input  wire [15:0] addr,
  input  wire        inc,
  input  wire        ring,
  input  wire        byte_sz,
  output wire [15:0] addr_next
);
  wire [15:0] sum;

  assign sum = addr + (byte_sz ? 16'h0001 : 16'h0002);
  // Ring keeps the upper bits, so the pointer wraps in an aligned block
  assign addr_next = !inc ? addr :
                     ring ? {addr[15:RING_AW], sum[RING_AW-1:0]} : sum;
endmodule

// [bench/dmc_props_properties.sv]
// ----------------------------------------------------------------
// Port-level checks on the transfer engine and register bus
// ----------------------------------------------------------------
module dmc_props #(
  parameter RING_AW = 5
) (
  input wire        sys_clk,
  input wire        resetn,
  input wire        mbus_req,
  input wire        mbus_we,
  input wire        mbus_byte,
  input wire [31:0] mbus_addr,
  input wire [15:0] mbus_wdata,
  input wire [15:0] mbus_rdata,
  input wire        mbus_ack,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] rd_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Read data one cycle back, to compare with what gets written
  always @(posedge sys_clk) begin
    rd_q <= mbus_rdata;
  end

  a_addr_window: assert property (mbus_req |-> mbus_addr[31:16] == 16'h0080)
    else $error("bus address outside window");
  a_read_first: assert property ($rose(mbus_req) |-> !mbus_we)
    else $error("transfer did not start with a read");
  a_phase_order: assert property (mbus_req && !mbus_we && mbus_ack |=> mbus_req && mbus_we)
    else $error("write phase did not follow read");
  a_bus_release: assert property (mbus_req && mbus_we && mbus_ack |=> !mbus_req [*2])
    else $error("bus not released after transfer");
  a_phase_hold: assert property (mbus_req && !mbus_ack |=>
    $stable(mbus_addr) && $stable(mbus_we) && $stable(mbus_byte))
    else $error("bus request changed before ack");
  a_data_copy: assert property (mbus_req && !mbus_we && mbus_ack |=>
    mbus_wdata[7:0] == rd_q[7:0] && (mbus_byte || mbus_wdata == rd_q))
    else $error("written data differs from read data");
  a_wdata_hold: assert property (mbus_req && mbus_we && !mbus_ack |=> $stable(mbus_wdata))
    else $error("write data changed before ack");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule

bind dmc_top dmc_props #(.RING_AW(RING_AW)) dmc_props_inst (
  .sys_clk(sys_clk), .resetn(resetn), .mbus_req(mbus_req), .mbus_we(mbus_we),
  .mbus_byte(mbus_byte), .mbus_addr(mbus_addr), .mbus_wdata(mbus_wdata),
  .mbus_rdata(mbus_rdata), .mbus_ack(mbus_ack), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// [bench/dmc_mem_model.sv]
// ----------------------------------------------------------------
// Internal bus slave: RAM and peripheral side, lat extra wait cycles
// ----------------------------------------------------------------
module dmc_mem_model (
  input  wire        clk,
  input  wire        rstn,
  input  wire [3:0]  lat,
  input  wire        req,
  input  wire        we,
  input  wire [31:0] addr,
  output logic [15:0] rdata,
  output logic       ack
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0]  cnt;
  logic [15:0] last;

  // Data only valid in the ack cycle; otherwise toggles so stale reads show
  always_comb rdata = (req && !we && ack) ? (addr[15:0] ^ 16'h5a5a) : ~last;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt  <= 4'h0;
      ack  <= 1'b0;
      last <= 16'h0;
    end else begin
      last <= rdata;
      ack  <= req && !ack && cnt >= lat;
      cnt  <= (req && !ack && cnt < lat) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// [bench/test_ten_channel_dma_controller.sv]
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, got, exp); end end

module test_ten_channel_dma_controller;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [11:0] aw_a = 12'h0, ar_a = 12'h0;
  logic [31:0] w_d = 32'h0;
  logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic [9:0]  rq_conv = 10'h0, rq_tudf = 10'h0, rq_tevt = 10'h0;
  logic [3:0]  lat = 4'h0;
  wire         aw_rdy, w_rdy, b_v, ar_rdy, r_v, m_req, m_we, m_byte, m_ack, irq;
  wire [1:0]   b_resp, r_resp;
  wire [31:0]  r_d, m_addr;
  wire [15:0]  m_wd, m_rd;
  logic [49:0] lg[$];
  int          error_cnt = 0, n_compared = 0, cyc = 0;

  dmc_top dmc_top_inst (
    .sys_clk(sys_clk), .resetn(resetn), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
    .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy), .s_axi_rdata(r_d),
    .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .src_req_conv(rq_conv),
    .src_req_tudf(rq_tudf), .src_req_tevt(rq_tevt), .mbus_req(m_req), .mbus_we(m_we),
    .mbus_byte(m_byte), .mbus_addr(m_addr), .mbus_wdata(m_wd), .mbus_rdata(m_rd),
    .mbus_ack(m_ack), .irq(irq)
  );
  dmc_mem_model dmc_mem_model_inst (
    .clk(sys_clk), .rstn(resetn), .lat(lat), .req(m_req), .we(m_we), .addr(m_addr),
    .rdata(m_rd), .ack(m_ack)
  );

  always #10 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Bus log and hang guard
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (resetn && m_req && m_ack) lg.push_back({m_byte, m_we, m_addr, m_we ? m_wd : m_rd});
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task give_verdict;
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Ready is raised only after valid is seen, so the hold case is exercised
  task automatic axi_wr(input [11:0] a, input [31:0] d, input [1:0] er = 2'b00);
    @(posedge sys_clk);
    aw_a <= a; aw_v <= 1'b1; w_d <= d; w_v <= 1'b1;
    for (int t = 0; t < 100; t++) begin
      @(posedge sys_clk);
      if (aw_v && aw_rdy) aw_v <= 1'b0;
      if (w_v && w_rdy) w_v <= 1'b0;
      if (b_v && b_r) break;
      if (b_v) b_r <= 1'b1;
    end
    b_r <= 1'b0;
    `CHK(b_v, 1'b1)
    `CHK(b_resp, er)
  endtask

  task automatic axi_rd(input [11:0] a, output logic [31:0] d, input [1:0] er = 2'b00);
    @(posedge sys_clk);
    ar_a <= a; ar_v <= 1'b1;
    for (int t = 0; t < 100; t++) begin
      @(posedge sys_clk);
      if (ar_v && ar_rdy) ar_v <= 1'b0;
      if (r_v && r_r) break;
      if (r_v) r_r <= 1'b1;
    end
    r_r <= 1'b0;
    `CHK(r_v, 1'b1)
    `CHK(r_resp, er)
    d = r_d;
  endtask

  task automatic rd_chk(input [11:0] a, input [31:0] e);
    logic [31:0] d;
    axi_rd(a, d);
    `CHK(d, e)
  endtask

  task automatic cfg(input int ch, input [7:0] ctl, input [7:0] cnt, input [15:0] s, d);
    logic [11:0] b;
    b = 12'h100 + 12'(ch * 16);
    axi_wr(b + 12'h4, {24'h0, cnt});
    axi_wr(b + 12'h8, {16'h0, s});
    axi_wr(b + 12'hc, {16'h0, d});
    axi_wr(b, {24'h0, ctl});
  endtask

  task automatic pulse(input int k, input int ch);
    @(posedge sys_clk);
    rq_conv <= (k == 1) ? 10'h001 << ch : 10'h000;
    rq_tudf <= (k == 2) ? 10'h001 << ch : 10'h000;
    rq_tevt <= (k == 3) ? 10'h001 << ch : 10'h000;
    @(posedge sys_clk);
    {rq_conv, rq_tudf, rq_tevt} <= 30'h0;
  endtask

  // Takes the next read and write seen on the internal bus
  task automatic exp_xfer(input [15:0] s, d, input byt);
    logic [15:0] v;
    v = s ^ 16'h5a5a;
    for (int t = 0; t < 300 && lg.size() < 2; t++) @(posedge sys_clk);
    `CHK(lg.size() >= 2, 1'b1)
    if (lg.size() >= 2) begin
      `CHK(lg[0], {byt, 1'b0, 16'h0080, s, v})
      `CHK(lg[1][49:16], {byt, 1'b1, 16'h0080, d})
      `CHK(lg[1][7:0], v[7:0])
      if (!byt) `CHK(lg[1][15:8], v[15:8])
      lg.delete(0);
      lg.delete(0);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    rd_chk(12'h100, 32'h0);
    rd_chk(12'h194, 32'h0);
    axi_rd(12'h0fc, d, 2'b10);
    axi_wr(12'h0f0, 32'h1, 2'b10);
  endtask

  task automatic t_basic;
    cfg(4, 8'h10, 8'h05, 16'h0110, 16'h0210);
    cfg(3, 8'hd0, 8'h01, 16'h0100, 16'h0200);
    axi_wr(12'h008, 32'h8);
    exp_xfer(16'h0100, 16'h0200, 1'b0);
    exp_xfer(16'h0110, 16'h0210, 1'b0);
    rd_chk(12'h134, 32'h0);
    rd_chk(12'h138, 32'h0102);
    rd_chk(12'h13c, 32'h0202);
  endtask

  task automatic t_prio;
    cfg(9, 8'h10, 8'h05, 16'h0190, 16'h0290);
    cfg(8, 8'h10, 8'h05, 16'h0180, 16'h0280);
    axi_wr(12'h008, 32'h110);
    exp_xfer(16'h0110, 16'h0210, 1'b0);
    exp_xfer(16'h0180, 16'h0280, 1'b0);
    exp_xfer(16'h0190, 16'h0290, 1'b0);
  endtask

  // Byte ring on a slow bus: 0x3F wraps to the start of its 32-byte block
  task automatic t_ring;
    lat <= 4'h3;
    cfg(7, 8'h75, 8'h01, 16'h003f, 16'h0300);
    pulse(1, 7);
    exp_xfer(16'h003f, 16'h0300, 1'b1);
    pulse(1, 7);
    exp_xfer(16'h0020, 16'h0300, 1'b1);
    rd_chk(12'h150, 32'h2);
    rd_chk(12'h000, 32'h80);
    lat <= 4'h0;
  endtask

  task automatic t_irq;
    cfg(5, 8'h10, 8'h03, 16'h0150, 16'h0250);
    cfg(0, 8'h10, 8'h00, 16'h0010, 16'h0020);
    axi_wr(12'h008, 32'h1);
    exp_xfer(16'h0010, 16'h0020, 1'b0);
    exp_xfer(16'h0150, 16'h0250, 1'b0);
    `CHK(irq, 1'b0)
    rd_chk(12'h104, 32'hff);
    rd_chk(12'h100, 32'h0);
    rd_chk(12'h110, 32'h2);
    rd_chk(12'h160, 32'h2);
    axi_wr(12'h004, 32'h1);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    rd_chk(12'h000, 32'h1);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    axi_wr(12'h110, 32'h2);
    rd_chk(12'h110, 32'h2);
    axi_wr(12'h110, 32'h0);
    rd_chk(12'h110, 32'h0);
    axi_wr(12'h110, 32'h2);
    rd_chk(12'h110, 32'h0);
  endtask

  task automatic t_sel;
    for (int k = 1; k < 4; k++) begin
      cfg(9, {3'b000, 1'b1, 2'(k), 2'b00}, 8'h05, 16'h0400, 16'h0500);
      pulse(k, 9);
      exp_xfer(16'h0400, 16'h0500, 1'b0);
    end
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_basic();
    t_prio();
    t_ring();
    t_irq();
    t_sel();
    give_verdict();
  end
endmodule
